//--- hw/pmp_pkg.sv
// shared constants for the port mac receive controls and ingress policer
package pmp_pkg;
    // ==========================================
    // register indices, byte address is four times the index
    localparam logic [11:0] IDX_XMII_CTRL = 12'h300;
    localparam logic [11:0] IDX_RX_CTRL = 12'h401;
    localparam logic [11:0] IDX_ING_CTRL = 12'h403;
    localparam logic [11:0] IDX_PRIO_BASE = 12'h410;
    localparam logic [11:0] IDX_STATUS = 12'h420;
    // ==========================================
    // internal register selects
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_XMII = 4'h1;
    localparam logic [3:0] SEL_RX = 4'h2;
    localparam logic [3:0] SEL_ING = 4'h3;
    localparam logic [3:0] SEL_STAT = 4'h4;
    // ==========================================
    // field positions
    localparam int BIT_RXFC = 3;
    localparam int BIT_BP = 3;
    localparam int BIT_PASS_ALL = 0;
    localparam int BIT_PORT_BASED = 6;
    localparam int BIT_PKT_MODE = 5;
    localparam int BIT_LIM_FC = 4;
    localparam int LMODE_LO = 2;
    localparam int BIT_GAP = 1;
    localparam int BIT_PRE = 0;
    // ==========================================
    // writable masks and values after reset
    localparam logic [7:0] MASK_XMII = 8'h08;
    localparam logic [7:0] MASK_RX = 8'hBF;
    localparam logic [7:0] MASK_ING = 8'h7F;
    localparam logic [7:0] RST_RX = 8'h00;
    localparam logic [7:0] RST_ING = 8'h00;
    localparam logic [6:0] RST_CODE = 7'h00;
    // ==========================================
    // limit mode encodings
    localparam logic [1:0] LM_ALL = 2'b00;
    localparam logic [1:0] LM_BMF = 2'b01;
    localparam logic [1:0] LM_BM = 2'b10;
    localparam logic [1:0] LM_B = 2'b11;
    // ==========================================
    // byte accounting
    localparam int GAP_BYTES = 12;
    localparam int PRE_BYTES = 8;
    localparam int PKT_COST = 7;      // byte credits per packet in packet mode
    localparam int LINE_RATE_INC = 1000; // code zero, one byte per Mb/s per tick
    localparam int STEP10 = 10;
    localparam int SLOW_INC = 1;
    localparam int LEN_W = 14;
    // ==========================================
    // refill timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int REFILL_NS = 8000;
    localparam int REFILL_CYC = (REFILL_NS * 1000) / CLK_PERIOD_PS;
endpackage

//--- hw/pmp_frame_class.sv
// frame classifier: counted-class match and bad-frame detection
`timescale 1ns/1ps
`default_nettype none
module pmp_frame_class (
    input wire logic [1:0] limit_mode,
    input wire logic is_bcast,
    input wire logic is_mcast,
    input wire logic is_flood,
    input wire logic crc_err,
    input wire logic too_long,
    input wire logic too_short,
    output logic counted,
    output logic bad
);
    // ==========================================
    // class match, one case per limit mode
    always_comb begin
        case (limit_mode)
            pmp_pkg::LM_ALL: counted = 1'b1;
            pmp_pkg::LM_BMF: counted = is_bcast | is_mcast | is_flood;
            pmp_pkg::LM_BM: counted = is_bcast | is_mcast;
            pmp_pkg::LM_B: counted = is_bcast;
            default: counted = 1'b1;
        endcase
    end

    // any of the three length or check errors marks the frame bad
    assign bad = crc_err | too_long | too_short;
endmodule
`default_nettype wire

//--- hw/pmp_fifo.sv
// small valid/ready buffer held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module pmp_fifo #(
    parameter int W = 19,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two of at least two");
    end
    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q, rd_q;
    logic [PW:0] cnt_q, cnt_d;
    logic push, pop;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    assign out_data = mem_q[rd_q];

    // pointers, fill level and registered flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_d;
            // ready is registered, so a full buffer stalls the source honestly
            in_ready <= cnt_d != (PW+1)'(DEPTH);
            out_valid <= cnt_d != '0;
        end
    end

    // storage, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) mem_q[wr_q] <= in_data;
    end
endmodule
`default_nettype wire

//--- hw/pmp_policer.sv
// port mac receive controls and ingress rate policer with apb registers
`timescale 1ns/1ps
`default_nettype none
module pmp_policer #(
    parameter int ADDR_W = 16,         // apb byte address width
    parameter int BKT_W = 16,          // credit bucket width in bits
    parameter int BURST = 16000,       // credit ceiling in bytes
    parameter int REFILL_CYC = pmp_pkg::REFILL_CYC, // cycles per refill tick
    parameter int FIFO_DEPTH = 2,      // output buffer depth
    parameter logic RXFC_RESET = 1'b0  // receive flow control after reset
) (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // received frame descriptors
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [pmp_pkg::LEN_W-1:0] rx_len,
    input wire logic [2:0] rx_prio,
    input wire logic rx_bcast,
    input wire logic rx_mcast,
    input wire logic rx_flood,
    input wire logic rx_crc_err,
    input wire logic rx_too_long,
    input wire logic rx_too_short,
    input wire logic rx_flow_ctrl,
    // port and switch state
    input wire logic full_duplex,
    input wire logic rx_congested,
    input wire logic fc_frame_filter_en,
    // forwarded descriptors
    output logic fwd_valid,
    input wire logic fwd_ready,
    output logic [pmp_pkg::LEN_W-1:0] fwd_len,
    output logic [2:0] fwd_prio,
    output logic fwd_normal,
    output logic fwd_mirror_only,
    // link partner regulation
    output logic bp_assert,
    output logic pause_assert
);
    // ==========================================
    // elaboration checks
    if (ADDR_W < 14 || ADDR_W > 32) begin : g_chk_addr
        $error("address width must lie between 14 and 32");
    end
    if (BKT_W < pmp_pkg::LEN_W + 1 || BURST >= (1 << BKT_W) - 1) begin : g_chk_bkt
        $error("bucket too narrow for the burst or frame length");
    end
    if (REFILL_CYC < 2) begin : g_chk_tick
        $error("refill period must be at least two cycles");
    end

    localparam int TW = $clog2(REFILL_CYC);
    localparam int DW = pmp_pkg::LEN_W + 5;

    // ==========================================
    // register decode
    // one decode serves both the read mux and the write strobes
    function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-3:0] w;
        w = a[ADDR_W-1:2];
        reg_sel = pmp_pkg::SEL_NONE;
        if (a[1:0] == 2'b00) begin
            if (w == (ADDR_W-2)'(pmp_pkg::IDX_XMII_CTRL)) reg_sel = pmp_pkg::SEL_XMII;
            if (w == (ADDR_W-2)'(pmp_pkg::IDX_RX_CTRL)) reg_sel = pmp_pkg::SEL_RX;
            if (w == (ADDR_W-2)'(pmp_pkg::IDX_ING_CTRL)) reg_sel = pmp_pkg::SEL_ING;
            if (w == (ADDR_W-2)'(pmp_pkg::IDX_STATUS)) reg_sel = pmp_pkg::SEL_STAT;
            // eight priority limits share one aligned block
            if (w[ADDR_W-3:3] == (ADDR_W-5)'(pmp_pkg::IDX_PRIO_BASE >> 3)) begin
                reg_sel = {1'b1, w[2:0]};
            end
        end
        return reg_sel;
    endfunction

    // ==========================================
    // rate code to byte credits per refill tick
    // slow codes are rounded up to one byte per tick, a coarse floor
    function automatic logic [BKT_W-1:0] rate_inc(input logic [6:0] code);
        if (code == 7'h00) begin
            return BKT_W'(pmp_pkg::LINE_RATE_INC);
        end else if (code <= 7'h0A) begin
            return BKT_W'(code);
        end else if (code <= 7'h64) begin
            return BKT_W'(code) * BKT_W'(pmp_pkg::STEP10);
        end else begin
            return BKT_W'(pmp_pkg::SLOW_INC);
        end
    endfunction

    // ==========================================
    // apb slave state
    logic [3:0] sel;             // decoded register of the current address
    logic wr_en;                 // write takes effect this edge
    logic [7:0] rd_d;            // read data for the current address
    logic [7:0] wbyte;           // low write byte
    logic [7:0] xmii_q;          // receive flow control enable register
    logic [7:0] rx_ctrl_q;       // receive control register
    logic [7:0] ing_ctrl_q;      // ingress policer control register
    logic [6:0] shadow_q [8];    // codes as written by software
    logic [6:0] active_q [8];    // codes the limiter really uses
    logic [7:0] over_vec;        // per bucket over-limit flags

    assign sel = reg_sel(paddr);
    assign wbyte = pwdata[7:0];
    // only the access edge with pready high commits a write
    assign wr_en = psel & penable & pready & pwrite & pstrb[0];

    // read mux, reserved bits read as zero except xmii_q bit 7, which reads as one once loaded
    always_comb begin
        rd_d = 8'h00;
        case (sel)
            pmp_pkg::SEL_XMII: rd_d = xmii_q;
            pmp_pkg::SEL_RX: rd_d = rx_ctrl_q;
            pmp_pkg::SEL_ING: rd_d = ing_ctrl_q;
            pmp_pkg::SEL_STAT: rd_d = over_vec;
            default: begin
                if (sel[3]) rd_d = {1'b0, shadow_q[sel[2:0]]};
            end
        endcase
    end

    // handshake: data prepared in setup, answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            if (psel & ~penable) begin
                prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_d};
                // unmapped or misaligned addresses answer with an error
                pslverr <= sel == pmp_pkg::SEL_NONE;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // ==========================================
    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ctrl_q <= pmp_pkg::RST_RX;
            ing_ctrl_q <= pmp_pkg::RST_ING;
        end else if (wr_en) begin
            if (sel == pmp_pkg::SEL_RX) rx_ctrl_q <= wbyte & pmp_pkg::MASK_RX;
            if (sel == pmp_pkg::SEL_ING) ing_ctrl_q <= wbyte & pmp_pkg::MASK_ING;
        end
    end

    // receive flow control enable, reset value is a build-time choice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xmii_q <= 8'h00;
        end else if (!xmii_q[7] && !wr_en) begin
            // first cycle after release loads the strap default once
            xmii_q <= {1'b1, 3'b000, RXFC_RESET, 3'b000};
        end else if (wr_en && sel == pmp_pkg::SEL_XMII) begin
            xmii_q <= {1'b1, 7'h00} | (wbyte & pmp_pkg::MASK_XMII);
        end
    end

    // ==========================================
    // priority limit codes with deferred commit
    for (genvar p = 0; p < 8; p++) begin : g_code
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                shadow_q[p] <= pmp_pkg::RST_CODE;
                active_q[p] <= pmp_pkg::RST_CODE;
            end else begin
                if (wr_en && sel == {1'b1, 3'(p)}) shadow_q[p] <= wbyte[6:0];
                // all eight codes move together when priority seven is written
                if (wr_en && sel == 4'hF) begin
                    active_q[p] <= (p == 7) ? wbyte[6:0] : shadow_q[p];
                end
            end
        end
    end

    // ==========================================
    // control bit views
    logic bp_en, pass_all, port_based, pkt_mode, lim_fc, cnt_gap, cnt_pre, rxfc;
    logic [1:0] lmode;
    assign bp_en = rx_ctrl_q[pmp_pkg::BIT_BP];
    assign pass_all = rx_ctrl_q[pmp_pkg::BIT_PASS_ALL];
    assign port_based = ing_ctrl_q[pmp_pkg::BIT_PORT_BASED];
    assign pkt_mode = ing_ctrl_q[pmp_pkg::BIT_PKT_MODE];
    assign lim_fc = ing_ctrl_q[pmp_pkg::BIT_LIM_FC];
    assign lmode = ing_ctrl_q[pmp_pkg::LMODE_LO+1:pmp_pkg::LMODE_LO];
    assign cnt_gap = ing_ctrl_q[pmp_pkg::BIT_GAP];
    assign cnt_pre = ing_ctrl_q[pmp_pkg::BIT_PRE];
    assign rxfc = xmii_q[pmp_pkg::BIT_RXFC];

    // ==========================================
    // refill tick
    logic [TW-1:0] tick_cnt_q;
    logic tick;
    assign tick = tick_cnt_q == TW'(REFILL_CYC - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
        end
    end

    // ==========================================
    // frame classification and cost
    logic counted, bad;
    pmp_frame_class u_class (
        .limit_mode(lmode),
        .is_bcast(rx_bcast),
        .is_mcast(rx_mcast),
        .is_flood(rx_flood),
        .crc_err(rx_crc_err),
        .too_long(rx_too_long),
        .too_short(rx_too_short),
        .counted(counted),
        .bad(bad)
    );

    logic [2:0] bkt_sel;          // bucket charged by this frame
    logic [BKT_W-1:0] cost;       // credits this frame needs
    logic [BKT_W-1:0] bkt_lvl [8];
    logic short;                  // not enough credit
    logic drop_fc, drop_bad, drop_rate, drop, accept, take;

    // port scope charges bucket zero, whose code is priority zero
    assign bkt_sel = port_based ? 3'h0 : rx_prio;

    // packet mode charges a flat amount, so gap and preamble bits drop out
    always_comb begin
        if (pkt_mode) begin
            cost = BKT_W'(pmp_pkg::PKT_COST);
        end else begin
            cost = BKT_W'(rx_len);
            if (cnt_gap) cost = cost + BKT_W'(pmp_pkg::GAP_BYTES);
            if (cnt_pre) cost = cost + BKT_W'(pmp_pkg::PRE_BYTES);
        end
    end

    assign short = counted & (bkt_lvl[bkt_sel] < cost);
    // flow-control frame filtering ignores the pass-all setting
    assign drop_fc = rx_flow_ctrl & fc_frame_filter_en;
    assign drop_bad = bad & ~pass_all;
    // with limiter flow control the partner is slowed instead
    assign drop_rate = short & ~lim_fc;
    assign drop = drop_fc | drop_bad | drop_rate;
    assign accept = rx_valid & rx_ready;
    // only frames that go on spend credit
    assign take = accept & counted & ~drop;

    // ==========================================
    // credit buckets, one per priority
    for (genvar p = 0; p < 8; p++) begin : g_bkt
        logic [BKT_W-1:0] lvl_q;
        logic over_q;
        logic [BKT_W:0] sum;
        logic hit;
        assign hit = bkt_sel == 3'(p);
        // refill and charge in one step, saturating both ways
        always_comb begin
            sum = {1'b0, lvl_q};
            if (tick) sum = sum + {1'b0, rate_inc(active_q[p])};
            if (take && hit) begin
                sum = (sum > {1'b0, cost}) ? sum - {1'b0, cost} : '0;
            end
            if (sum > (BKT_W+1)'(BURST)) sum = (BKT_W+1)'(BURST);
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lvl_q <= '0;
                over_q <= 1'b0;
            end else begin
                lvl_q <= sum[BKT_W-1:0];
                // a new excess beats the clear on the same tick
                if (accept && short && hit) begin
                    over_q <= 1'b1;
                end else if (tick) begin
                    over_q <= 1'b0;
                end
            end
        end
        assign bkt_lvl[p] = lvl_q;
        assign over_vec[p] = over_q;
    end

    // ==========================================
    // forwarding buffer
    logic push_valid, push_normal, push_mirror;
    // bad frames kept by pass-all reach the mirror only
    assign push_normal = ~bad;
    assign push_mirror = bad & pass_all;
    assign push_valid = rx_valid & ~drop;
    logic [DW-1:0] push_data, pop_data;
    assign push_data = {rx_len, rx_prio, push_normal, push_mirror};
    logic fifo_ready;
    // a dropped frame still waits for room, keeping one ready for all
    assign rx_ready = fifo_ready;

    pmp_fifo #(
        .W(DW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(push_valid),
        .in_ready(fifo_ready),
        .in_data(push_data),
        .out_valid(fwd_valid),
        .out_ready(fwd_ready),
        .out_data(pop_data)
    );
    assign fwd_len = pop_data[DW-1:5];
    assign fwd_prio = pop_data[4:2];
    assign fwd_normal = pop_data[1];
    assign fwd_mirror_only = pop_data[0];

    // ==========================================
    // link partner regulation
    logic rate_fc;
    // software must also have enabled port flow control for this to reach the link
    assign rate_fc = lim_fc & (|over_vec);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bp_assert <= 1'b0;
            pause_assert <= 1'b0;
        end else begin
            // collisions are forced only on a half duplex link
            bp_assert <= bp_en & ~full_duplex & (rx_congested | rate_fc);
            // pause uses its own enable and never looks at bp_en
            pause_assert <= full_duplex & rxfc & rate_fc;
        end
    end
endmodule
`default_nettype wire

//--- verif/pmp_props.sv
// concurrent checks on the policer's apb and forwarding ports
`timescale 1ns/1ps
`default_nettype none
module pmp_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic full_duplex,
    input wire logic fwd_valid,
    input wire logic fwd_ready,
    input wire logic [pmp_pkg::LEN_W-1:0] fwd_len,
    input wire logic fwd_normal,
    input wire logic fwd_mirror_only,
    input wire logic bp_assert,
    input wire logic pause_assert
);
    // ========================================
    // one clock domain, so one default clock and disable
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // zero wait states: answer in the first access cycle
    AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
        else $error("no answer after apb setup");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready held too long");
    // a refused read returns zero, registers are one byte wide
    AST_ERR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    AST_RD_HIGH: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    // ========================================
    // partner regulation follows the duplex mode
    AST_BP_HALF: assert property (bp_assert |-> $past(!full_duplex))
        else $error("back pressure in full duplex");
    AST_PAUSE_FULL: assert property (pause_assert |-> $past(full_duplex))
        else $error("pause in half duplex");
    // bad frames never reach ordinary forwarding
    AST_MIRROR: assert property (fwd_valid && fwd_mirror_only |-> !fwd_normal)
        else $error("mirror frame marked for forwarding");
    // a stalled descriptor must keep its length and not vanish
    AST_FWD_HOLD: assert property (fwd_valid && !fwd_ready |=> fwd_valid && $stable(fwd_len))
        else $error("stalled descriptor changed");
endmodule
bind pmp_policer pmp_props pmp_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .full_duplex(full_duplex), .fwd_valid(fwd_valid), .fwd_ready(fwd_ready),
    .fwd_len(fwd_len), .fwd_normal(fwd_normal), .fwd_mirror_only(fwd_mirror_only),
    .bp_assert(bp_assert), .pause_assert(pause_assert));
`default_nettype wire

//--- verif/pmp_policer_bench.sv
// self-checking bench for the receive controls and ingress policer
`timescale 1ns/1ps
`default_nettype none
module pmp_policer_bench;
    // ========================================
    // short aliases for the register indices
    localparam logic [11:0] RX = pmp_pkg::IDX_RX_CTRL;
    localparam logic [11:0] ING = pmp_pkg::IDX_ING_CTRL;
    localparam logic [11:0] XM = pmp_pkg::IDX_XMII_CTRL;
    localparam logic [11:0] PR = pmp_pkg::IDX_PRIO_BASE;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, rx_valid = 1'h0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, rx_ready, fwd_valid, fwd_normal, fwd_mirror_only;
    logic bp_assert, pause_assert, lm, ln;
    logic [16:0] lq; // last forwarded priority and length
    logic [13:0] rx_len = 14'h0, fwd_len;
    logic [2:0] rx_prio = 3'h0, fwd_prio;
    logic [6:0] rx_kind = 7'h0; // flow ctrl, short, long, crc, flood, mcast, bcast
    logic full_duplex = 1'h0, rx_congested = 1'h0, fc_filt = 1'h0, fwd_ready = 1'h1;
    int bad_count = 0, n_tests = 0, nf = 0, np = 0;
    // small refill period and ceiling keep the limiter cases short
    pmp_policer #(.ADDR_W(16), .REFILL_CYC(4), .BURST(200)) pmp_policer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_len(rx_len),
        .rx_prio(rx_prio), .rx_bcast(rx_kind[0]), .rx_mcast(rx_kind[1]),
        .rx_flood(rx_kind[2]), .rx_crc_err(rx_kind[3]), .rx_too_long(rx_kind[4]),
        .rx_too_short(rx_kind[5]), .rx_flow_ctrl(rx_kind[6]), .full_duplex(full_duplex),
        .rx_congested(rx_congested), .fc_frame_filter_en(fc_filt), .fwd_valid(fwd_valid),
        .fwd_ready(fwd_ready), .fwd_len(fwd_len), .fwd_prio(fwd_prio),
        .fwd_normal(fwd_normal), .fwd_mirror_only(fwd_mirror_only),
        .bp_assert(bp_assert), .pause_assert(pause_assert));
    // 40 MHz clock
    initial forever #12.5 pclk = ~pclk;
    // counted on the falling edge so tasks never race the monitor
    always @(negedge pclk) begin
        if (fwd_valid === 1'h1 && fwd_ready === 1'h1) begin
            nf++;
            lm = fwd_mirror_only;
            ln = fwd_normal;
            lq = {fwd_prio, fwd_len};
        end
        if (pause_assert === 1'h1) np++;
    end
    // ========================================
    // comparison, verdict and timeout
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic tmo;
        bad_count++;
        $display("unexpected at %0t: wait ran out", $time);
        print_verdict;
    endtask
    // apb master: setup, access until pready, then one idle edge
    task automatic ap(input logic w, input logic [11:0] x, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int i;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= {2'h0, x, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        if (i == 20) tmo;
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] x, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        ap(1'h1, x, {24'h0, d}, r, e);
    endtask
    task automatic rdc(input logic [11:0] x, input logic [31:0] d, input logic ee);
        logic [31:0] r;
        logic e;
        ap(1'h0, x, 32'h0, r, e);
        chk(r, d);
        chk({31'h0, e}, {31'h0, ee});
    endtask
    // one descriptor, valid held until taken; callers may chain
    task automatic fr(input logic [13:0] l, input logic [2:0] p, input logic [6:0] k);
        int i;
        rx_len <= l;
        rx_prio <= p;
        rx_kind <= k;
        rx_valid <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (rx_ready === 1'h1) break;
        end
        if (i == 50) tmo;
    endtask
    // go idle and count what came out
    task automatic fchk(input int e);
        rx_valid <= 1'h0;
        repeat (6) @(posedge pclk);
        chk(nf, e);
        nf = 0;
    endtask
    // ========================================
    // scenarios
    task automatic t_reg;
        rdc(RX, {24'h0, pmp_pkg::RST_RX}, 1'h0);
        rdc(XM, 32'h80, 1'h0);
        wr(ING, 8'hFF);
        rdc(ING, 32'h7F, 1'h0);
        rdc(12'h7FF, 32'h0, 1'h1);
    endtask
    task automatic t_bad;
        wr(ING, 8'h0C);
        wr(RX, 8'h00);
        fr(60, 0, 7'h08);
        fchk(0);
        wr(RX, 8'h01);
        fr(60, 0, 7'h08);
        fchk(1);
        chk({lm, ln}, 2'h2);
        fc_filt <= 1'h1;
        fr(60, 0, 7'h40);
        fchk(0);
        fc_filt <= 1'h0;
        fr(60, 0, 7'h40);
        fchk(1);
    endtask
    // every mode against every class; 300 bytes is always over the ceiling
    task automatic t_mode;
        wr(RX, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(ING, {4'h0, m[1:0], 2'h0});
            for (int c = 0; c < 4; c++) begin
                fr(300, 0, (c == 3) ? 7'h0 : 7'(1 << c));
                fchk(int'(c >= 4 - m));
            end
        end
    endtask
    // stall the far side, fill until refused, then drain
    task automatic t_buf;
        int k;
        k = 0;
        wr(ING, 8'h0C);
        fwd_ready <= 1'h0;
        rx_len <= 60;
        rx_kind <= 7'h0;
        rx_valid <= 1'h1;
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            if (rx_ready !== 1'h1) break;
            k++;
        end
        rx_valid <= 1'h0;
        chk(k, 2);
        repeat (4) @(posedge pclk);
        chk(nf, 0);
        fwd_ready <= 1'h1;
        fchk(2);
    endtask
    // slow code on priority 0 only bites once priority 7 is written
    task automatic t_lim;
        wr(ING, 8'h03);
        wr(PR, 8'h65);
        fr(100, 0, 7'h0);
        fchk(1);
        fr(150, 0, 7'h0);
        fchk(1);
        wr(PR + 12'h7, 8'h65);
        fr(100, 0, 7'h0);
        fr(63, 0, 7'h0);
        fchk(1);
        fr(150, 1, 7'h0);
        fchk(1);
        chk(lq, {3'h1, 14'h096});
        wr(ING, 8'h43);
        fr(150, 1, 7'h0);
        fchk(0);
        wr(ING, 8'h63);
        fr(150, 1, 7'h0);
        fchk(1);
    endtask
    task automatic t_fc;
        wr(RX, 8'h08);
        rx_congested <= 1'h1;
        repeat (3) @(posedge pclk);
        chk(bp_assert, 1);
        full_duplex <= 1'h1;
        repeat (3) @(posedge pclk);
        chk(bp_assert, 0);
        for (int j = 0; j < 3; j++) begin
            wr(XM, (j == 1) ? 8'h00 : 8'h08);
            wr(ING, (j == 2) ? 8'h03 : 8'h13);
            np = 0;
            repeat (4) fr(300, 0, 7'h0);
            fchk((j == 2) ? 0 : 4);
            chk(np != 0, j == 0);
        end
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_reg;
        t_bad;
        t_mode;
        t_buf;
        t_lim;
        t_fc;
        print_verdict;
    end
endmodule
`default_nettype wire
